// ===== hw/ssp_regs.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// ---------------------------------------------------------------
module ssp_regs
  import ssp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        ser_clk,
  input  wire logic        ser_data,
  input  wire logic        load_strobe,
  output logic [10:0]      main_divide_value,
  output logic [11:0]      fraction_numerator,
  output logic [6:0]       prescaler_cycle_count,
  output logic [1:0]       plus_four_count,
  output logic [1:0]       plus_one_count,
  output logic             prescaler_select,
  output logic [1:0]       modulator_order,
  output logic [1:0]       dither_level,
  output logic             spare_bit_mod,
  output logic [11:0]      divide_ratio,
  output logic [7:0]       latch_written,
  output logic [15:0]      lock_count,
  output logic             lock_restart
);
  // ---------------------------------------------------------------
  // link side and crossing
  // ---------------------------------------------------------------
  logic [23:0] cap_word;    // word frozen at strobe rise
  logic        cap_tgl;     // toggles per strobe rise
  logic        tgl_s;       // toggle after two flops
  logic        tgl_d;       // previous synced toggle
  logic [23:0] latch [8];   // internal latches
  logic [7:0]  sel_hot;     // one-hot latch select, all zero for select code 1
  logic        load_ev;     // one clk pulse per load

  ssp_shift u_shift (
    .ser_clk     (ser_clk),
    .ser_data    (ser_data),
    .load_strobe (load_strobe),
    .word        (cap_word),
    .load_tgl    (cap_tgl)
  );

  ssp_sync u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d       (cap_tgl),
    .q       (tgl_s)
  );

  // edge of the synced toggle marks one load event
  assign load_ev = tgl_s ^ tgl_d;
  // cap_word is stable for many clk cycles after the toggle, so it is
  // safe to read once the toggle has passed two flops
  assign sel_hot = ssp_sel_dec(cap_word[SEL_W-1:0]);

  always_ff @(posedge clk) begin
    if (sys_rst) tgl_d <= 1'b0;
    else         tgl_d <= tgl_s;
  end

  // ---------------------------------------------------------------
  // latch bank: only the selected latch updates
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    for (int i = 0; i < NLATCH; i++) begin
      if (sys_rst) begin
        latch[i] <= LATCH_RST;
      end else if (load_ev && sel_hot[i]) begin
        latch[i] <= cap_word;
      end
    end
  end

  // ---------------------------------------------------------------
  // field decode from latches
  // ---------------------------------------------------------------
  wire [10:0] n_val   = latch[0][N_LSB +: N_W];
  wire [11:0] fn_val  = latch[0][FN_LSB +: FN_W];
  wire        psel    = latch[1][PSEL_BIT];
  wire [1:0]  ord_val = latch[3][ORDER_LSB +: 2];
  wire [1:0]  dit_val = latch[3][DITHER_LEVEL_LSB +: 2];
  // split of N: base 8 takes C from bits 9..3, base 16 from bits 10..4
  wire [6:0]  c_small = n_val[9:3];
  wire [6:0]  c_large = n_val[10:4];
  wire [6:0]  c_val   = psel ? c_large : c_small;
  wire [1:0]  b_val   = psel ? n_val[3:2] : {1'b0, n_val[2]};
  wire [1:0]  a_val   = n_val[1:0];
  // small prescaler leaves B msb free: modulator takes it
  wire        spare   = ~psel;
  // ratio rebuilt from the split; matches N for a legal word
  wire [11:0] base_c  = psel ? {1'b0, c_val, 4'h0} : {2'b00, c_val, 3'h0};
  wire [11:0] ratio   = base_c + {8'h00, b_val, 2'b00} + {10'h000, a_val};

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      main_divide_value     <= 11'h000;
      fraction_numerator    <= 12'h000;
      prescaler_cycle_count <= 7'h00;
      plus_four_count       <= 2'h0;
      plus_one_count        <= 2'h0;
      prescaler_select      <= 1'b0;
      modulator_order       <= 2'h0;
      dither_level          <= 2'h0;
      spare_bit_mod         <= 1'b0;
      divide_ratio          <= 12'h000;
    end else begin
      main_divide_value     <= n_val;
      fraction_numerator    <= fn_val;
      prescaler_cycle_count <= c_val;
      plus_four_count       <= b_val;
      plus_one_count        <= a_val;
      prescaler_select      <= psel;
      modulator_order       <= ord_val;
      dither_level          <= dit_val;
      spare_bit_mod         <= spare;
      divide_ratio          <= ratio;
    end
  end

  // ---------------------------------------------------------------
  // latch-written flags and lock restart
  // ---------------------------------------------------------------
  // restart only zeroes the counter; the latches above are untouched
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      latch_written <= 8'h00;
      lock_restart  <= 1'b0;
      lock_count    <= 16'h0000;
    end else begin
      latch_written <= load_ev ? sel_hot : 8'h00;
      lock_restart  <= load_ev && sel_hot[0];
      if (load_ev && sel_hot[0]) begin
        lock_count <= 16'h0000;
      end else if (lock_count != 16'hffff) begin
        lock_count <= lock_count + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// ===== hw/ssp_pkg.sv
package ssp_pkg;
  // ---------------------------------------------------------------
  // word layout
  // ---------------------------------------------------------------
  localparam int WORD_W       = 24;  // programming word length
  localparam int SEL_W        = 4;   // address select field width
  localparam int NLATCH       = 8;   // number of internal latches
  localparam int N_LSB        = 13;  // main divide value low bit
  localparam int N_W          = 11;  // main divide value width
  localparam int FN_LSB       = 1;   // fraction numerator low bit
  localparam int FN_W         = 12;  // fraction numerator width
  localparam int A_W          = 2;   // plus one count width
  localparam int B_W          = 2;   // plus four count width
  localparam int C_W          = 7;   // prescaler cycle count width
  // prescaler select, modulator order, dither: control latch fields
  localparam int PSEL_BIT     = 22;  // prescaler select in latch 1
  localparam int ORDER_LSB    = 4;   // modulator order in latch 3
  localparam int DITHER_LEVEL_LSB     = 6;   // dither level in latch 3
  localparam logic [23:0] LATCH_RST = 24'h000000; // latch reset value
  localparam logic [3:0]  BASE_SMALL = 4'h8; // small prescaler modulus
  localparam logic [4:0]  BASE_LARGE = 5'h10; // large prescaler modulus
  localparam int LOCK_CNT_W   = 16;  // lock counter width

  // modulator order codes
  typedef enum logic [1:0] {
    SSP_ORD4 = 2'b00,
    SSP_RSV  = 2'b01,
    SSP_ORD2 = 2'b10,
    SSP_ORD3 = 2'b11
  } ssp_order_e;

  // dither codes
  typedef enum logic [1:0] {
    SSP_DITHER_LEVEL_OFF    = 2'b00,
    SSP_DITHER_LEVEL_WEAK   = 2'b01,
    SSP_DITHER_LEVEL_STRONG = 2'b10,
    SSP_DITHER_LEVEL_RSV    = 2'b11
  } ssp_dither_level_e;

  // decoded main divider settings
  typedef struct packed {
    logic [10:0] main_divide_value;
    logic [11:0] fraction_numerator;
    logic [6:0]  prescaler_cycle_count;
    logic [1:0]  plus_four_count;
    logic [1:0]  plus_one_count;
    logic        prescaler_select;
    ssp_order_e  modulator_order;
    ssp_dither_level_e   dither_level;
  } ssp_div_s;

  // latch select decode
  function automatic logic [7:0] ssp_sel_dec(input logic [3:0] s);
    logic [7:0] d;
    d = 8'h00;
    if (!s[0]) d[0] = 1'b1;
    else if (s[3:1] != 3'h0) d[s[3:1]] = 1'b1;
    return d;
  endfunction
endpackage

// ===== hw/ssp_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-flop level synchroniser
module ssp_sync
  import ssp_pkg::*;
(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic d,
  output logic      q
);
  logic meta; // first stage, read only by q
  // ---------------------------------------------------------------
  // sync stages
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta <= 1'b0;
      q    <= 1'b0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
`default_nettype wire

// ===== hw/ssp_shift.sv
`timescale 1ns/1ps
`default_nettype none
// serial-clock shift register with load toggle out
module ssp_shift
  import ssp_pkg::*;
(
  input  wire logic        ser_clk,
  input  wire logic        ser_data,
  input  wire logic        load_strobe,
  output logic [23:0]      word,
  output logic             load_tgl
);
  // link registers have no reset pin; they take their idle value at
  // power-up instead, so the first strobe rise gives a clean toggle
  logic [23:0] sr     = 24'h000000; // live shift register
  logic [23:0] word_q = 24'h000000; // word frozen at strobe rise
  logic        tgl_q  = 1'b0;       // flips once per strobe rise
  assign word     = word_q;
  assign load_tgl = tgl_q;
  // ---------------------------------------------------------------
  // shift, msb first, while strobe low
  // ---------------------------------------------------------------
  always_ff @(posedge ser_clk) begin
    if (!load_strobe) begin
      sr <= {sr[22:0], ser_data};
    end
  end
  // ---------------------------------------------------------------
  // capture word on strobe rise; toggle flags the event
  // ---------------------------------------------------------------
  // the strobe is an async edge, so the word is frozen here and
  // stays stable while the toggle crosses to clk
  always_ff @(posedge load_strobe) begin
    word_q <= sr;
    tgl_q  <= ~tgl_q;
  end
endmodule
`default_nettype wire

// ===== testbench/ssp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------
// host side serial driver
// ------
// idle: clock parked low, strobe high; set by initialisers so no
// false strobe edge appears at time zero
module ssp_host_model (
  output logic ser_clk     = 1'b0,
  output logic ser_data    = 1'b0,
  output logic load_strobe = 1'b1
);
  // junk bits go first so only the trailing word may count
  task automatic send(input logic [23:0] w, input int junk);
    logic [29:0] s;
    s = {6'h2a, w};
    load_strobe = 1'b0;
    #24;
    for (int i = 23 + junk; i >= 0; i--) begin
      ser_data = s[i];
      #24 ser_clk = 1'b1;
      #24 ser_clk = 1'b0;
    end
    #24 load_strobe = 1'b1;
    ser_data = ~ser_data; // released line keeps no stale bit
  endtask
endmodule
`default_nettype wire

// ===== testbench/ssp_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ------
// port checker
// ------
module ssp_regs_checker
  import ssp_pkg::*;
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [10:0] main_divide_value,
  input wire logic [11:0] fraction_numerator,
  input wire logic        prescaler_select,
  input wire logic [1:0]  modulator_order,
  input wire logic [1:0]  dither_level,
  input wire logic        spare_bit_mod,
  input wire logic [7:0]  latch_written,
  input wire logic [15:0] lock_count
  ,input wire logic       lock_restart
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // a main word load, then the next cycle
  sequence s_load0;
    lock_restart ##1 1'b1;
  endsequence
  a_one_latch: assert property ($onehot0(latch_written))
    else $error("more than one latch loaded");
  a_restart_main: assert property (lock_restart == latch_written[0])
    else $error("restart not tied to main word load");
  a_pulse_once: assert property (|latch_written |=> !(|latch_written))
    else $error("load pulse longer than one cycle");
  a_count_clear: assert property (s_load0 |-> lock_count < 16'h0003)
    else $error("lock counter not cleared");
  a_main_hold: assert property (!latch_written[0] |=>
    $stable(main_divide_value) && $stable(fraction_numerator))
    else $error("main divider changed without load");
  a_psel_hold: assert property (!latch_written[1] |=>
    $stable(prescaler_select)) else $error("prescaler changed");
  a_order_hold: assert property (!latch_written[3] |=>
    $stable({modulator_order, dither_level})) else $error("order changed");
  a_spare_bit: assert property ($stable(prescaler_select)[*2] |->
    spare_bit_mod == !prescaler_select) else $error("spare bit wrong");
endmodule
bind ssp_regs ssp_regs_checker ssp_regs_checker_inst (.clk, .sys_rst,
  .main_divide_value, .fraction_numerator, .prescaler_select,
  .modulator_order, .dither_level, .spare_bit_mod, .latch_written,
  .lock_count, .lock_restart);
`default_nettype wire

// ===== testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ------
// register bank bench
// ------
module testbench;
  import ssp_pkg::*;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  wire logic   ser_clk, ser_data, load_strobe;
  logic [10:0] main_divide_value;
  logic [11:0] fraction_numerator, divide_ratio;
  logic [6:0]  prescaler_cycle_count;
  logic [1:0]  plus_four_count, plus_one_count, modulator_order, dither_level;
  logic        prescaler_select, spare_bit_mod, lock_restart;
  logic [7:0]  latch_written, seen;
  logic [15:0] lock_count;
  logic        rst_seen;
  int          mismatches = 0;
  int          n_tests = 0;
  localparam logic [10:0] NV = 11'h1f3; // legal for both prescalers
  // N of 499 is above 30, so any modulator order is allowed
  // no denominator above 4095 and no extended word needed
  always #5 clk = ~clk;
  ssp_host_model ssp_host_model_inst (.ser_clk, .ser_data, .load_strobe);
  ssp_regs ssp_regs_inst (.clk, .sys_rst, .ser_clk, .ser_data,
    .load_strobe, .main_divide_value, .fraction_numerator,
    .prescaler_cycle_count, .plus_four_count, .plus_one_count,
    .prescaler_select, .modulator_order, .dither_level, .spare_bit_mod,
    .divide_ratio, .latch_written, .lock_count, .lock_restart);
  task automatic chk(input string what, input logic [23:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask
  // send a word, gather its load pulses over the answer window
  task automatic wr(input logic [23:0] w, input int junk,
                    input logic [7:0] hot);
    ssp_host_model_inst.send(w, junk);
    seen = 8'h00;
    rst_seen = 1'b0;
    repeat (8) begin
      @(posedge clk);
      #1;
      seen = seen | latch_written;
      rst_seen = rst_seen | lock_restart;
    end
    chk("latch_written", 24'(hot), 24'(seen));
    chk("lock_restart", 24'(hot[0]), 24'(rst_seen));
  endtask
  // divider split expected from the rebuilt prescaler layout
  task automatic chk_div(input logic p);
    logic [6:0] c;
    logic [1:0] b;
    c = p ? NV[10:4] : NV[9:3];
    b = p ? NV[3:2] : {1'b0, NV[2]};
    chk("main_n", 24'(NV), 24'(main_divide_value));
    chk("c_count", 24'(c), 24'(prescaler_cycle_count));
    chk("b_count", 24'(b), 24'(plus_four_count));
    chk("a_count", 24'(NV[1:0]), 24'(plus_one_count));
    chk("ratio", 24'(NV), 24'(divide_ratio));
    chk("spare", 24'(!p), 24'(spare_bit_mod));
  endtask
  task automatic stop_test();
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // watchdog: a full run needs about 15 us
  initial begin
    #300us;
    mismatches++;
    stop_test();
  end
  initial begin
    repeat (20) @(posedge clk);
    #1 sys_rst = 1'b0;
    chk("n_reset", 24'h0, 24'(main_divide_value));
    wr({NV, 12'hc35, 1'b0}, 0, 8'h01);
    chk("numerator", 24'h000c35, 24'(fraction_numerator));
    chk_div(1'b0);
    $display("test main word done");
    wr({2'b01, 18'h0, 4'h3}, 6, 8'h02);
    chk_div(1'b1);
    $display("test prescaler done");
    for (int i = 0; i < 3; i++) begin
      wr({16'h0, 2'(i), 2'(i == 0 ? 0 : 4 - i), 4'h7}, 0, 8'h08);
      chk("order", 24'(i == 0 ? 0 : 4 - i), 24'(modulator_order));
      chk("dither", 24'(i), 24'(dither_level));
    end
    $display("test order dither done");
    for (int s = 1; s < 16; s += 2) begin
      if (s != 3 && s != 7) begin
        wr({20'h5a5a5, 4'(s)}, 0, s == 1 ? 8'h00 : 8'h01 << s[3:1]);
      end
    end
    chk_div(1'b1);
    $display("test other latches done");
    stop_test();
  end
endmodule
`default_nettype wire
